// ==== hdl/wdog_defines.svh ====
/*
 * Offsets, field positions, reset values and timing figures of the
 * watchdog and reset-cause block.
 * Assumes a 250 MHz system clock; included by bare name.
 */
`ifndef WDOG_DEFINES_SVH
`define WDOG_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define WD_CTRL_ADDR    8'h0A
`define WD_FLAGS_ADDR   8'h09

// ****************************************
// field positions
// ****************************************
`define WD_EN_BIT       7
`define WD_TRIP_BIT     6
`define WD_FAULT_BIT    7
`define WD_POR_BIT      6
`define WD_BACKUP_BIT   5
`define WD_KEY          4'hA
`define WD_CTRL_RST     8'h00

// ****************************************
// timing
// ****************************************
`define WD_CLK_MHZ      250
`define WD_STEP_MS      100
`define WD_PULSE_MS     100
`define WD_STEP_CYC     (`WD_STEP_MS * 1000 * `WD_CLK_MHZ)
`define WD_PULSE_CYC    (`WD_PULSE_MS * 1000 * `WD_CLK_MHZ)

`endif

// ==== hdl/wdog_pkg.sv ====
/*
 * Types shared by the watchdog block and its bench.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package wdog_pkg;

  typedef struct packed {
    logic       enable;
    logic       trip_point_select;
    logic       rsvd;
    logic [4:0] timeout_select;
  } ctrl_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [0:0] {
    PULSE_IDLE = 1'b0,
    PULSE_HOLD = 1'b1
  } pulse_state_t;

endpackage

// ==== hdl/watchdog_reset_flags.sv ====
/*
 * Watchdog timer with reset-cause flags and supply trip select.
 * Assumes a byte register port driven by the serial slave on the same
 * clock; supply, manual reset and backup level arrive from pins.
 */
// Summary of operation
// - enabled timeout drives reset output low
// - disabled: timer runs, sets flag, no reset
// - 5-bit select, 100 ms steps, 0 invalid
// - new select loaded only at restart
// - control bit picks 3.9V or 4.4V trip
// - key 1010b in low nibble restarts timer
// - upper nibble ignored for restart decision
// - other low nibble leaves timer alone
// - timeout sets sticky watchdog fault flag
// - supply or manual reset sets por flag
// - por flag holds until software clears
// - fault and por flags independent
// - low backup at power-up sets flag
// - flags hw set, sw clear; key write-only
`timescale 1ns/1ps
`include "wdog_defines.svh"

module watchdog_reset_flags
  import wdog_pkg::*;
#(
  parameter int TICK_CYCLES  = `WD_STEP_CYC,
  parameter int PULSE_CYCLES = `WD_PULSE_CYC
) (
  // clock and reset
  input  wire logic     clock,
  input  wire logic     sys_rst,
  // register port
  input  wire reg_req_t reg_req,
  output logic [7:0]    reg_rdata,
  // pins
  input  wire logic     supply_low,
  input  wire logic     manual_rst_n,
  input  wire logic     backup_supply_low,
  output logic          rst_out_n,
  output logic          trip_point_select
);

  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam int QW = $clog2(PULSE_CYCLES + 1);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] sup_q;
  logic [1:0] man_q;
  logic [1:0] bak_q;
  logic       sup_s;
  logic       man_s;
  logic       bak_s;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sup_q <= 2'h0;
      man_q <= 2'h3;
      bak_q <= 2'h0;
    end else begin
      sup_q <= {sup_q[0], supply_low};
      man_q <= {man_q[0], manual_rst_n};
      bak_q <= {bak_q[0], backup_supply_low};
    end
  end

  assign sup_s = sup_q[1];
  assign man_s = !man_q[1];
  assign bak_s = bak_q[1];

  // ****************************************
  // register decode
  // ****************************************
  ctrl_t ctrl_r;
  logic  wr_ctrl;
  logic  wr_flags;
  logic  restart;

  assign wr_ctrl  = reg_req.wr && reg_req.addr == `WD_CTRL_ADDR;
  assign wr_flags = reg_req.wr && reg_req.addr == `WD_FLAGS_ADDR;
  // only the low nibble is compared
  assign restart  = wr_flags && reg_req.wdata[3:0] == `WD_KEY;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= ctrl_t'(`WD_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_r      <= ctrl_t'(reg_req.wdata);
      ctrl_r.rsvd <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      trip_point_select <= 1'b0;
    end else begin
      trip_point_select <= ctrl_r.trip_point_select;
    end
  end

  // ****************************************
  // timebase and timeout counter
  // ****************************************
  logic [PW-1:0] pre_r;
  logic [4:0]    tick_cnt_r;
  logic [4:0]    act_sel_r;
  logic          tick;
  logic          expire;

  assign tick   = pre_r == PW'(TICK_CYCLES - 1);
  // code zero never expires, so an unset select cannot fault
  assign expire = tick && act_sel_r != 5'h00 &&
                  tick_cnt_r == act_sel_r - 5'h01;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pre_r <= '0;
    end else if (restart || tick) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + PW'(1);
    end
  end

  // free-running: wraps at expiry whatever the enable says
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_r <= 5'h00;
    end else if (restart || expire) begin
      tick_cnt_r <= 5'h00;
    end else if (tick) begin
      tick_cnt_r <= tick_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      act_sel_r <= 5'h00;
    end else if (restart) begin
      act_sel_r <= ctrl_r.timeout_select;
    end
  end

  // ****************************************
  // watchdog reset pulse
  // ****************************************
  pulse_state_t  pst_r;
  logic [QW-1:0] pcnt_r;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pst_r  <= PULSE_IDLE;
      pcnt_r <= '0;
    end else begin
      case (pst_r)
        PULSE_IDLE: begin
          if (expire && ctrl_r.enable) begin
            pst_r  <= PULSE_HOLD;
            pcnt_r <= '0;
          end
        end
        PULSE_HOLD: begin
          if (pcnt_r == QW'(PULSE_CYCLES - 1)) begin
            pst_r <= PULSE_IDLE;
          end
          pcnt_r <= pcnt_r + QW'(1);
        end
        default: begin
          pst_r <= PULSE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rst_out_n <= 1'b0;
    end else begin
      rst_out_n <= !(sup_s || man_s || pst_r == PULSE_HOLD);
    end
  end

  // ****************************************
  // reset-cause flags
  // ****************************************
  logic       fault_r;
  logic       por_r;
  logic       backup_low_r;
  logic [1:0] backup_age_r;
  logic       clr_fault;
  logic       clr_por;
  logic       clr_backup;

  // writing zero clears; writing one leaves the flag as is
  assign clr_fault  = wr_flags && !reg_req.wdata[`WD_FAULT_BIT];
  assign clr_por    = wr_flags && !reg_req.wdata[`WD_POR_BIT];
  assign clr_backup = wr_flags && !reg_req.wdata[`WD_BACKUP_BIT];

  // set beats a clear landing in the same cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fault_r <= 1'b0;
    end else if (expire) begin
      fault_r <= 1'b1;
    end else if (clr_fault) begin
      fault_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      por_r <= 1'b0;
    end else if (sup_s || man_s) begin
      por_r <= 1'b1;
    end else if (clr_por) begin
      por_r <= 1'b0;
    end
  end

  // backup level is judged once, after the synchroniser has filled
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      backup_age_r <= 2'h0;
      backup_low_r <= 1'b0;
    end else begin
      if (backup_age_r != 2'h3) begin
        backup_age_r <= backup_age_r + 2'h1;
      end
      // third edge: first one at which the synchroniser holds the pin
      if (backup_age_r == 2'h2 && bak_s) begin
        backup_low_r <= 1'b1;
      end else if (clr_backup) begin
        backup_low_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        `WD_CTRL_ADDR:  reg_rdata <= ctrl_r;
        `WD_FLAGS_ADDR: reg_rdata <= {fault_r, por_r, backup_low_r, 5'h00};
        default:        reg_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_fault_armed;
    expire && ctrl_r.enable && pst_r == PULSE_IDLE;
  endsequence

  sequence s_pulse_low;
    (pst_r == PULSE_HOLD && !rst_out_n) [*3];
  endsequence

  a_fault_pulse_out: assert property (
    @(posedge clock) disable iff (sys_rst)
    s_fault_armed |=> ##1 s_pulse_low)
    else $error("enabled timeout did not pull reset low");

  a_disabled_no_reset: assert property (
    @(posedge clock) disable iff (sys_rst)
    expire && !ctrl_r.enable && pst_r == PULSE_IDLE
      |=> pst_r == PULSE_IDLE && fault_r)
    else $error("disabled watchdog acted on reset");

  a_key_restart: assert property (
    @(posedge clock) disable iff (sys_rst)
    restart |=> pre_r == '0 && tick_cnt_r == 5'h00)
    else $error("key write did not restart timer");

  a_other_key_keeps: assert property (
    @(posedge clock) disable iff (sys_rst)
    wr_flags && reg_req.wdata[3:0] != `WD_KEY && !tick
      |=> pre_r == $past(pre_r) + PW'(1))
    else $error("non-key write disturbed timer");

  a_select_latched: assert property (
    @(posedge clock) disable iff (sys_rst)
    wr_ctrl && !restart |=> $stable(act_sel_r))
    else $error("timeout select took effect without restart");

  a_fault_flag_set: assert property (
    @(posedge clock) disable iff (sys_rst)
    expire |=> fault_r)
    else $error("timeout did not set fault flag");

  a_por_flag_set: assert property (
    @(posedge clock) disable iff (sys_rst)
    (sup_s || man_s) |=> por_r && !rst_out_n)
    else $error("supply or manual reset missed por flag");

  a_flags_sticky: assert property (
    @(posedge clock) disable iff (sys_rst)
    por_r && !clr_por |=> por_r)
    else $error("por flag cleared without software write");

  a_backup_sticky: assert property (
    @(posedge clock) disable iff (sys_rst)
    backup_low_r && !clr_backup |=> backup_low_r)
    else $error("backup flag cleared without software write");

  a_pulse_length: assert property (
    @(posedge clock) disable iff (sys_rst)
    pst_r == PULSE_HOLD |-> pcnt_r < QW'(PULSE_CYCLES))
    else $error("reset pulse ran past its length");

  a_trip_follows: assert property (
    @(posedge clock) disable iff (sys_rst)
    wr_ctrl ##2 1 |-> trip_point_select == $past(reg_req.wdata[6], 2))
    else $error("trip select not following control bit");

endmodule // watchdog_reset_flags

// ==== tb/host_model.sv ====
/*
 * Host side: byte reads and writes on the register port.
 * Assumes the block's clock and a registered read answer.
 */
`timescale 1ns/1ps
module host_model
  import wdog_pkg::*;
(
  // clock
  input  wire logic       clock,
  // register port
  output reg_req_t        reg_req,
  input  wire logic [7:0] reg_rdata
);
  initial reg_req = '0;

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clock);
    reg_req.wr <= 1'b0;
  endtask

  // extra edge: answer is registered after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    reg_req.rd <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    v = reg_rdata;
  endtask
endmodule // host_model

// ==== tb/test_watchdog_reset_flags.sv ====
/*
 * Self-checking bench of the watchdog and reset-cause flags.
 * Assumes short tick and pulse counts; host_model drives the port.
 */
`timescale 1ns/1ps
`include "wdog_defines.svh"
module test_watchdog_reset_flags;
  localparam int TICK  = 10;
  localparam int PULSE = 8;
  logic               clock, sys_rst, supply_low, manual_rst_n;
  logic               backup_supply_low, rst_out_n, trip_point_select;
  logic [7:0]         reg_rdata, d, v;
  wdog_pkg::reg_req_t reg_req;
  int                 num_errors, check_count, n;

  watchdog_reset_flags #(.TICK_CYCLES(TICK), .PULSE_CYCLES(PULSE)) uut (
    .clock(clock), .sys_rst(sys_rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .supply_low(supply_low),
    .manual_rst_n(manual_rst_n), .backup_supply_low(backup_supply_low),
    .rst_out_n(rst_out_n), .trip_point_select(trip_point_select));
  host_model host (.clock(clock), .reg_req(reg_req),
    .reg_rdata(reg_rdata));

  // ****************************************
  // checking
  // ****************************************
  task automatic check(input string w, input logic [7:0] s,
                       input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] in_win(int c, int sel);
    return (c >= sel * TICK - 2 && c <= sel * TICK + 5) ? 8'h01 : 8'h00;
  endfunction

  // counts cycles until the reset output goes low
  task automatic time_low(output int c);
    c = 0;
    while (rst_out_n !== 1'b0) begin
      @(negedge clock);
      c++;
      if (c > 400) begin
        num_errors++;
        end_sim();
      end
    end
  endtask

  task automatic pulse_len(output int c);
    c = 0;
    while (rst_out_n === 1'b0) begin
      @(negedge clock);
      c++;
      if (c > 400) begin
        num_errors++;
        end_sim();
      end
    end
  endtask

  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    sys_rst = 1'b1;
    supply_low = 1'b0;
    manual_rst_n = 1'b1;
    backup_supply_low = 1'b1;
    num_errors = 0;
    check_count = 0;
    void'($urandom(80));
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clock);
    backup_supply_low <= 1'b0;
    host.rd(`WD_CTRL_ADDR, d);
    check("ctrl reset", d, `WD_CTRL_RST);
    host.rd(`WD_FLAGS_ADDR, d);
    check("flags reset", d, 8'h20);
    host.wr(`WD_FLAGS_ADDR, 8'h00);
    host.rd(`WD_FLAGS_ADDR, d);
    check("backup cleared", d, 8'h00);
    host.rd(8'($urandom_range(8'h0B, 8'hFF)), d);
    check("unmapped", d, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom) & 8'h7F;
      v[6] = i[0];
      host.wr(`WD_CTRL_ADDR, v);
      host.rd(`WD_CTRL_ADDR, d);
      check("ctrl readback", d, v & 8'hDF);
      check("trip pin", {7'h00, trip_point_select}, {7'h00, v[6]});
    end
    // enabling only after a restart gives a full first interval
    host.wr(`WD_CTRL_ADDR, 8'h03);
    host.wr(`WD_FLAGS_ADDR, {4'($urandom), 4'hA});
    host.wr(`WD_CTRL_ADDR, 8'h81);
    time_low(n);
    check("old select kept", in_win(n + 2, 3), 8'h01);
    pulse_len(n);
    check("pulse length", 8'(n), 8'(PULSE));
    host.rd(`WD_FLAGS_ADDR, d);
    check("fault flag", d, 8'h80);
    host.wr(`WD_FLAGS_ADDR, 8'h0A);
    time_low(n);
    check("one step", in_win(n, 1), 8'h01);
    // restart inside the pulse: with one step the next expiry
    // lands one step after the restart, four cycles past the pulse end
    host.wr(`WD_FLAGS_ADDR, 8'h0A);
    pulse_len(n);
    host.wr(`WD_FLAGS_ADDR, {4'h0, 4'($urandom_range(0, 9))});
    time_low(n);
    check("no restart", in_win(n + 8, 1), 8'h01);
    pulse_len(n);
    // disabled: timer still expires, output stays high
    host.wr(`WD_CTRL_ADDR, 8'h02);
    host.wr(`WD_FLAGS_ADDR, 8'h0A);
    repeat (PULSE + 4) @(posedge clock);
    repeat (40) begin
      @(negedge clock);
      check("no reset", {7'h00, rst_out_n}, 8'h01);
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      if (i == 0) begin
        manual_rst_n <= 1'b0;
      end else begin
        supply_low <= 1'b1;
      end
      repeat (5) @(posedge clock);
      check("cause reset", {7'h00, rst_out_n}, 8'h00);
      manual_rst_n <= 1'b1;
      supply_low <= 1'b0;
      repeat (5) @(posedge clock);
      host.rd(`WD_FLAGS_ADDR, d);
      check("both flags", d, 8'hC0);
      host.wr(`WD_FLAGS_ADDR, 8'h80);
      host.rd(`WD_FLAGS_ADDR, d);
      check("por cleared", d, 8'h80);
    end
    end_sim();
  end
endmodule // test_watchdog_reset_flags
